// ==== pot_slave.sv ====
// potentiometer end of the link: write buffer and slave engine
`timescale 1ns/1ns
// ============================================================
// write buffer fifo
module pot_fifo
  import pot_link_pkg::*;
#(
  parameter int W     = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  // depth must be a power of two for the wrap bit
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;     // storage
    logic [AW:0]             wr_ptr;  // write pointer plus wrap
    logic [AW:0]             rd_ptr;  // read pointer plus wrap
  } fifo_t;
  fifo_t q, d;
  logic full, empty;
  assign full  = (q.wr_ptr[AW] != q.rd_ptr[AW]) &&
                 (q.wr_ptr[AW-1:0] == q.rd_ptr[AW-1:0]);
  assign empty = (q.wr_ptr == q.rd_ptr);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = q.mem[q.rd_ptr[AW-1:0]];
  // ==========================================================
  // next state
  always_comb begin
    d = q;
    if (in_valid && in_ready) begin
      d.mem[q.wr_ptr[AW-1:0]] = in_data;
      d.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (out_valid && out_ready) begin
      d.rd_ptr = q.rd_ptr + 1'b1;
    end
  end
  // registers, frozen while ce is low
  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end
endmodule

// ============================================================
// slave engine
// What this block does, with RQ7 done by the master end
// (RQ1) start is data falling while clock high
// (RQ2) stop is data rising while clock high
// (RQ3) stop after a read gives standby
// (RQ4) data changes under clock high are conditions
// (RQ5) pull data low through ninth clock
// (RQ6) standby after reset, stop, internal work
// (RQ7) master recovers bus with nine clocks, start
// (RQ8) address byte shifted in msb first
// (RQ9) select pin is one address bit
// (RQ10) writes only while protect pin is low
// (RQ11) position msb discarded, seven bits kept
// (RQ12) memory write starts only after stop
// (RQ13) address is 101000, select, read/write
// (RQ14) mismatch: no acknowledge, back to idle
// (RQ15) during memory write ignore bus entirely
// (RQ16) positions start at 127
// (RQ17) start or stop mid-byte abandons byte
module pot_slave
  import pot_link_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire logic                          ce,
  pot_bus_if.slave                           bus,
  input  wire logic                          address_select_pin,
  input  wire logic                          write_protect,
  output logic [POT_COUNT-1:0][POT_W-1:0]    wiper_pos,
  output logic                               standby,
  output logic                               nv_busy
);
  localparam int NVW = $clog2(NV_CYCLES + 1);
  localparam int PIW = $clog2(POT_COUNT);
  typedef enum logic [2:0] {
    S_IDLE, S_DEV, S_MEM, S_WR, S_RD, S_NVW
  } slave_st_t;
  typedef struct packed {
    logic                       scl_m, scl_s;  // clock synchroniser
    logic                       sda_m, sda_s;  // data synchroniser
    logic                       sel_m, sel_s;  // select pin sync
    logic                       wp_m,  wp_s;   // protect pin sync
    logic                       scl_p, sda_p;  // previous levels
    slave_st_t                  st;            // protocol state
    logic [3:0]                 cnt;           // bit counter
    logic [7:0]                 sr;            // receive shifter
    logic [7:0]                 tx;            // transmit shifter
    logic                       mack;          // master acked
    logic                       sda_oe;        // we pull data low
    logic [7:0]                 memaddr;       // memory pointer
    logic [POT_COUNT-1:0][POT_W-1:0] pot;      // wiper positions
    logic [NVW-1:0]             nvcnt;         // write timer
    logic                       standby;       // low-power flag
    logic                       nv_busy;       // memory write flag
  } slave_t;
  slave_t q, d;
  logic rise, fall, start_c, stop_c, match;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [FIFO_W-1:0] fifo_out_data;

  // read value of a pointer; unmapped bytes read zero
  function automatic logic [7:0] pot_byte(
    input logic [POT_COUNT-1:0][POT_W-1:0] p,
    input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a < 8'(POT_COUNT)) begin
      r = {1'b0, p[a[PIW-1:0]]};
    end
    return r;
  endfunction

  // ==========================================================
  // line events, from synchronised levels only
  assign rise    = q.scl_s & ~q.scl_p;
  assign fall    = ~q.scl_s & q.scl_p;
  assign start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s; // [RQ1] [RQ4]
  assign stop_c  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s; // [RQ2] [RQ4]
  assign match   = (q.sr[7:2] == DEV_ADDR_FIXED) &&
                   (q.sr[1] == q.sel_s);                   // [RQ13] [RQ9]
  // only unlocked data bytes reach the buffer
  assign fifo_in_valid  = (q.st == S_WR) && fall &&
                          (q.cnt == ACK_SLOT) && ~q.wp_s;  // [RQ10]
  assign fifo_out_ready = (q.st == S_NVW);

  pot_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_buf (
    .mclk      (mclk),
    .srst      (srst),
    .ce        (ce),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({q.memaddr, q.sr}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ==========================================================
  // protocol next state
  always_comb begin
    d = q;
    d.scl_m = bus.scl;
    d.scl_s = q.scl_m;
    d.sda_m = bus.sda;
    d.sda_s = q.sda_m;
    d.sel_m = address_select_pin;
    d.sel_s = q.sel_m;
    d.wp_m  = write_protect;
    d.wp_s  = q.wp_m;
    d.scl_p = q.scl_s;
    d.sda_p = q.sda_s;
    if (q.st == S_NVW) begin
      // bus is deaf here, data line stays released
      d.sda_oe = 1'b0;                                     // [RQ15]
      if (fifo_out_valid) begin
        // commit buffered bytes, top bit dropped
        if (fifo_out_data[15:8] < 8'(POT_COUNT)) begin
          d.pot[fifo_out_data[8+PIW-1:8]] = fifo_out_data[6:0]; // [RQ11]
        end
      end else if (q.nvcnt == NVW'(NV_CYCLES - 1)) begin
        d.st = S_IDLE;                                     // [RQ6]
      end else begin
        d.nvcnt = q.nvcnt + 1'b1;
      end
    end else if (stop_c) begin
      d.sda_oe = 1'b0;
      d.cnt    = 4'h0;
      if (q.st == S_WR && fifo_out_valid) begin
        d.st    = S_NVW;                                   // [RQ12]
        d.nvcnt = '0;
      end else begin
        d.st = S_IDLE;                                     // [RQ2] [RQ3]
      end
    end else if (start_c) begin
      // any partial byte is thrown away
      d.st     = S_DEV;                                    // [RQ17] [RQ1]
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        S_IDLE: begin
          // commands without a start are ignored
          d.sda_oe = 1'b0;                                 // [RQ1]
        end
        S_RD: begin
          if (rise && q.cnt < ACK_SLOT) begin
            d.tx  = {q.tx[6:0], 1'b0};
            d.cnt = q.cnt + 1'b1;
          end else if (rise && q.cnt == ACK_SLOT) begin
            d.mack = ~q.sda_s;
            d.cnt  = ACK_DONE;
          end else if (fall && q.cnt < ACK_SLOT) begin
            d.sda_oe = ~q.tx[7];
          end else if (fall && q.cnt == ACK_SLOT) begin
            d.sda_oe = 1'b0;   // master owns the ack slot
          end else if (fall && q.cnt == ACK_DONE) begin
            d.cnt     = 4'h0;
            d.memaddr = q.memaddr + 8'h01;
            if (q.mack) begin
              d.tx     = pot_byte(q.pot, q.memaddr + 8'h01);
              d.sda_oe = ~d.tx[7];
            end else begin
              d.st = S_IDLE;   // wait for the stop
            end
          end
        end
        default: begin
          // address, pointer and data bytes
          if (rise && q.cnt < ACK_SLOT) begin
            d.sr  = {q.sr[6:0], q.sda_s};                  // [RQ8] [RQ4]
            d.cnt = q.cnt + 1'b1;
          end else if (fall && q.cnt == ACK_SLOT) begin
            d.cnt = ACK_DONE;
            if (q.st == S_DEV) begin
              if (match) begin
                d.sda_oe = 1'b1;                           // [RQ5]
              end else begin
                d.st  = S_IDLE;                            // [RQ14]
                d.cnt = 4'h0;
              end
            end else if (q.st == S_WR) begin
              // locked bytes are acked but dropped
              d.sda_oe = q.wp_s | fifo_in_ready;           // [RQ5] [RQ10]
              if (fifo_in_valid && fifo_in_ready) begin
                d.memaddr[PAGE_BITS-1:0] =
                  q.memaddr[PAGE_BITS-1:0] + 1'b1;
              end
            end else begin
              d.sda_oe = 1'b1;                             // [RQ5]
            end
          end else if (fall && q.cnt == ACK_DONE) begin
            d.sda_oe = 1'b0;
            d.cnt    = 4'h0;
            if (q.st == S_DEV) begin
              if (q.sr[0] == RW_READ) begin
                d.st     = S_RD;
                d.tx     = pot_byte(q.pot, q.memaddr);
                d.sda_oe = ~d.tx[7];
              end else begin
                d.st = S_MEM;
              end
            end else if (q.st == S_MEM) begin
              d.memaddr = q.sr;
              d.st      = S_WR;
            end
          end
        end
      endcase
    end
    d.standby = (d.st == S_IDLE);                          // [RQ6] [RQ3]
    d.nv_busy = (d.st == S_NVW);
  end

  // registers, frozen while ce is low
  always_ff @(posedge mclk) begin
    if (srst) begin
      q         <= '0;
      q.st      <= S_IDLE;
      q.pot     <= {POT_COUNT{POT_DEFAULT}};               // [RQ16]
      q.standby <= 1'b1;                                   // [RQ6]
    end else if (ce) begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = q.sda_oe;
  assign wiper_pos    = q.pot;
  assign standby      = q.standby;
  assign nv_busy      = q.nv_busy;
endmodule

// ==== pot_link_pkg.sv ====
// shared constants of the two-wire potentiometer link
package pot_link_pkg;
  // ==========================================================
  // addressing
  localparam logic [5:0] DEV_ADDR_FIXED = 6'h28; // 101000 binary
  localparam logic       RW_READ        = 1'b1;  // high selects read
  // ==========================================================
  // potentiometers
  localparam int         POT_COUNT   = 3;
  localparam int         POT_W       = 7;
  localparam logic [6:0] POT_DEFAULT = 7'h7f;    // max resistance
  localparam int         PAGE_BITS   = 3;        // 8-byte page wrap
  // ==========================================================
  // byte framing: bit counter values
  localparam logic [3:0] ACK_SLOT = 4'h8;        // 8 bits taken
  localparam logic [3:0] ACK_DONE = 4'h9;        // ninth clock seen
  // ==========================================================
  // timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int NV_WRITE_MS     = 10;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * (CLK_HZ / 1000);
  localparam int SCL_QTR_CYCLES  = 25;           // 100 kHz link clock
  // ==========================================================
  // write buffer
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 16;                // {address, data}
  // ==========================================================
  // master symbol and operation kinds
  localparam logic [1:0] SYM_START = 2'h0;
  localparam logic [1:0] SYM_TX    = 2'h1;
  localparam logic [1:0] SYM_RX    = 2'h2;
  localparam logic [1:0] SYM_STOP  = 2'h3;
  localparam logic [1:0] OP_RECOV  = 2'h0;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;
endpackage

// ==== pot_bus_if.sv ====
// open-drain two-wire bus joining master and slave
`timescale 1ns/1ns
interface pot_bus_if;
  logic m_scl_o;   // master clock level when driven
  logic m_scl_oe;  // master pulls clock
  logic m_sda_o;   // master data level when driven
  logic m_sda_oe;  // master pulls data
  logic s_sda_o;   // slave data level when driven
  logic s_sda_oe;  // slave pulls data
  wire  scl;       // resolved clock line
  wire  sda;       // resolved data line
  // open drain: a driven low wins, otherwise the pull-up
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
                  input  scl, sda);
  modport slave  (output s_sda_o, s_sda_oe,
                  input  scl, sda);
endinterface

// ==== pot_master.sv ====
// master end of the link: clock divider and symbol sequencer
`timescale 1ns/1ns
module pot_master
  import pot_link_pkg::*;
#(
  parameter int QTR = SCL_QTR_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  pot_bus_if.master       bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic       cmd_sel,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_data,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            rsp_nack
);
  localparam int DW = $clog2(QTR + 1);
  typedef enum logic {H_IDLE, H_RUN} master_st_t;
  typedef struct packed {
    master_st_t  st;        // idle or running a sequence
    logic [1:0]  op;        // recovery, write or read
    logic [2:0]  step;      // symbol index
    logic [3:0]  cnt;       // bit within byte symbol
    logic [1:0]  qtr;       // quarter of a bit
    logic [DW-1:0] div;     // quarter timer
    logic [7:0]  sh;        // transmit shifter
    logic [7:0]  rx;        // receive shifter
    logic        sel, rd;   // latched command
    logic [7:0]  addr, data;
    logic        sda_m, sda_s;  // data line synchroniser
    logic        scl_low, sda_low;
    logic        ready, rsp, nack;
  } master_t;
  master_t q, d;
  logic [9:0] cur, nxt;
  logic       tick;

  // symbol table: {kind, byte} for a step of an operation
  function automatic logic [9:0] sym(input master_t s,
                                     input logic [2:0] n);
    logic [7:0] dw, dr;
    logic [9:0] r;
    dw = {DEV_ADDR_FIXED, s.sel, ~RW_READ};
    dr = {DEV_ADDR_FIXED, s.sel, RW_READ};
    r  = {SYM_STOP, 8'h00};
    case (s.op)
      OP_RECOV: begin
        // nine released clocks, start, stop
        case (n)
          3'h0:    r = {SYM_TX, 8'hff};                    // [RQ7]
          3'h1:    r = {SYM_START, 8'h00};                 // [RQ7]
          default: r = {SYM_STOP, 8'h00};
        endcase
      end
      OP_WRITE: begin
        case (n)
          3'h0:    r = {SYM_START, 8'h00};                 // [RQ1]
          3'h1:    r = {SYM_TX, dw};                       // [RQ8]
          3'h2:    r = {SYM_TX, s.addr};
          3'h3:    r = {SYM_TX, s.data};
          default: r = {SYM_STOP, 8'h00};
        endcase
      end
      default: begin
        // dummy write of the pointer, restart, read one
        case (n)
          3'h0:    r = {SYM_START, 8'h00};
          3'h1:    r = {SYM_TX, dw};
          3'h2:    r = {SYM_TX, s.addr};
          3'h3:    r = {SYM_START, 8'h00};
          3'h4:    r = {SYM_TX, dr};
          3'h5:    r = {SYM_RX, 8'h00};
          default: r = {SYM_STOP, 8'h00};
        endcase
      end
    endcase
    return r;
  endfunction

  assign cur  = sym(q, q.step);
  assign nxt  = sym(q, q.step + 3'h1);
  assign tick = (q.div == DW'(QTR - 1));

  // ==========================================================
  // sequencer next state
  always_comb begin
    d       = q;
    d.sda_m = bus.sda;
    d.sda_s = q.sda_m;
    d.rsp   = 1'b0;
    case (q.st)
      H_IDLE: begin
        d.scl_low = 1'b0;
        d.sda_low = 1'b0;
        if (cmd_valid && q.ready) begin
          d.st    = H_RUN;
          d.op    = cmd_read ? OP_READ : OP_WRITE;
          d.sel   = cmd_sel;
          d.rd    = cmd_read;
          d.addr  = cmd_addr;
          d.data  = cmd_data;
          d.step  = 3'h0;
          d.cnt   = 4'h0;
          d.qtr   = 2'h0;
          d.div   = '0;
          d.nack  = 1'b0;
          d.ready = 1'b0;
        end
      end
      default: begin
        d.div = tick ? '0 : q.div + 1'b1;
        if (tick) begin
          d.qtr = q.qtr + 2'h1;
          case (q.qtr)
            2'h0: begin
              // data moves only while clock is low
              d.scl_low = 1'b1;                            // [RQ4]
              case (cur[9:8])
                SYM_START: d.sda_low = 1'b0;
                SYM_STOP:  d.sda_low = 1'b1;
                SYM_TX:    d.sda_low = (q.cnt < ACK_SLOT) & ~q.sh[7];
                default:   d.sda_low = 1'b0;  // rx and nack slot
              endcase
            end
            2'h1: d.scl_low = 1'b0;
            2'h2: begin
              if (cur[9:8] == SYM_START) begin
                d.sda_low = 1'b1;                          // [RQ1]
              end else if (cur[9:8] == SYM_STOP) begin
                d.sda_low = 1'b0;
              end else if (cur[9:8] == SYM_TX) begin
                if (q.cnt == ACK_SLOT && q.sda_s && q.op != OP_RECOV) begin
                  d.nack = 1'b1;
                end
              end else if (q.cnt < ACK_SLOT) begin
                d.rx = {q.rx[6:0], q.sda_s};
              end
            end
            default: begin
              if (cur[9:8] == SYM_TX || cur[9:8] == SYM_RX) begin
                d.scl_low = 1'b1;
                d.sh      = {q.sh[6:0], 1'b0};
                d.cnt     = q.cnt + 1'b1;
              end
              if (cur[9:8] == SYM_STOP) begin
                d.st    = H_IDLE;
                d.ready = 1'b1;
                d.rsp   = (q.op != OP_RECOV);
              end else if (cur[9:8] != SYM_TX && cur[9:8] != SYM_RX ||
                           q.cnt == ACK_SLOT) begin
                d.step = q.step + 3'h1;
                d.cnt  = 4'h0;
                d.sh   = nxt[7:0];
              end
            end
          endcase
        end
      end
    endcase
  end

  // registers; reset starts the bus recovery sequence
  always_ff @(posedge mclk) begin
    if (srst) begin
      q    <= '0;
      q.st <= H_RUN;                                       // [RQ7]
      q.op <= OP_RECOV;
      q.sh <= 8'hff;
    end else if (ce) begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = q.scl_low;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = q.sda_low;
  assign cmd_ready    = q.ready;
  assign rsp_valid    = q.rsp;
  assign rsp_data     = q.rx;
  assign rsp_nack     = q.nack;
endmodule

// ==== pot_bus_chk.sv ====
// checker of the two-wire link between master and slave ends
`timescale 1ns/1ns
module pot_bus_chk (
  input wire logic mclk,
  input wire logic srst,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ==========================================================
  // helper: frame, bit count and direction seen on the wires
  logic       scl_q, sda_q, busy_q, first_q, rw_q;
  logic [3:0] bit_q;   // rises taken in this byte, 8 = ack slot
  wire        start_w; // data falls, clock high
  wire        stop_w;  // data rises, clock high
  assign start_w = scl & scl_q & sda_q & ~sda;
  assign stop_w  = scl & scl_q & ~sda_q & sda;
  // raw wires, no synchroniser: the bus is driven by registers
  always_ff @(posedge mclk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (srst) begin
      busy_q  <= 1'b0;
      first_q <= 1'b0;
      rw_q    <= 1'b0;
      bit_q   <= 4'h0;
    end else if (start_w) begin
      busy_q  <= 1'b1;
      first_q <= 1'b1;
      bit_q   <= 4'h0;
    end else if (stop_w) begin
      busy_q <= 1'b0;
    end else if (scl & ~scl_q) begin
      bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      if (first_q && bit_q == 4'h7) rw_q <= sda;
      if (bit_q == 4'h8) first_q <= 1'b0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ack: rises then stands for eight more cycles
  sequence ack_seq;
    $rose(s_sda_oe) ##1 s_sda_oe [*8];
  endsequence
  a_data_stable: assert property (
    scl && scl_q |-> $stable(s_sda_oe))
    else $error("slave data moved while clock high");
  // master moves data only away from the clock release
  a_master_hold: assert property (
    $fell(m_scl_oe) |-> $stable(m_sda_oe))
    else $error("master data moved as clock released");
  a_pull_low_clk: assert property ($rose(s_sda_oe) |-> !scl)
    else $error("slave pull began with clock high");
  a_pull_in_frame: assert property (s_sda_oe |-> busy_q)
    else $error("slave pulled data outside a frame");
  a_ack_slot: assert property (
    $rose(s_sda_oe) && !rw_q |-> bit_q == 4'h8)
    else $error("acknowledge not after eighth bit");
  a_ack_hold: assert property ($rose(s_sda_oe) && !rw_q |-> ack_seq)
    else $error("acknowledge too short");
  a_ack_release: assert property (
    $fell(s_sda_oe) && !rw_q |-> bit_q == 4'h0 && !scl)
    else $error("acknowledge released at wrong time");
  a_stop_quiet: assert property (stop_w |=> !s_sda_oe [*2])
    else $error("slave pulled data after stop");
  a_reset_quiet: assert property ($fell(srst) |-> !s_sda_oe)
    else $error("slave pulled data out of reset");
endmodule

// ==== tb.sv ====
// bench joining master and slave ends over the two-wire bus
`timescale 1ns/1ns
module tb;
  import pot_link_pkg::*;
  localparam int NV  = 2000;  // long enough to overlap a poll
  localparam int LIM = 40000; // whole run ceiling in cycles
  logic                         mclk, srst, ce, cmd_valid, cmd_read;
  logic                         cmd_sel, sel_pin, wp, cmd_ready;
  logic                         rsp_valid, rsp_nack, standby, nv_busy;
  logic [7:0]                   cmd_addr, cmd_data, rsp_data;
  logic [POT_COUNT-1:0][POT_W-1:0] wiper_pos;
  int                           bad_count, comparisons, cyc;
  logic [7:0]                   vals [3] = '{8'h80, 8'hff, 8'h35};
  // ==========================================================
  // the two ends, the bus and its checker
  pot_bus_if pot_bus_if_i ();
  pot_master #(.QTR(8)) pot_master_i (.mclk(mclk), .srst(srst),
    .ce(ce), .bus(pot_bus_if_i), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_sel(cmd_sel),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  pot_slave #(.NV_CYCLES(NV)) pot_slave_i (.mclk(mclk), .srst(srst),
    .ce(ce), .bus(pot_bus_if_i), .address_select_pin(sel_pin),
    .write_protect(wp), .wiper_pos(wiper_pos), .standby(standby),
    .nv_busy(nv_busy));
  pot_bus_chk pot_bus_chk_i (.mclk(mclk), .srst(srst),
    .m_scl_oe(pot_bus_if_i.m_scl_oe), .m_sda_oe(pot_bus_if_i.m_sda_oe),
    .s_sda_oe(pot_bus_if_i.s_sda_oe), .scl(pot_bus_if_i.scl),
    .sda(pot_bus_if_i.sda));
  always #50 mclk = ~mclk;
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIM) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // one command, whole; values seen are those of the edge
  task automatic run_cmd(input logic rd, input logic s,
                         input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_sel   <= s;
    cmd_addr  <= a;
    cmd_data  <= d;
    @(posedge mclk);
    n = 0;
    do begin
      @(posedge mclk);
      cmd_valid <= 1'b0;
      n++;
    end while (rsp_valid !== 1'b1 && n < 5000);
    chk("response", 8'h01, {7'h0, rsp_valid});
  endtask
  // waits out the memory write, then standby must show
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (nv_busy !== 1'b0 && n < 5000);
    repeat (2) @(posedge mclk);
    chk("standby", 8'h01, {7'h0, standby});
  endtask
  task automatic t_reset();
    run_cmd(1'b1, 1'b0, 8'h03, 8'h00);
    for (int i = 0; i < POT_COUNT; i++)
      chk("reset pos", 8'h7f, {1'b0, wiper_pos[i]});
    $display("test reset done");
  endtask
  task automatic t_write();
    wp <= 1'b0;
    for (int i = 0; i < POT_COUNT; i++) begin
      run_cmd(1'b0, 1'b0, 8'(i), vals[i]);
      chk("write nack", 8'h00, {7'h0, rsp_nack});
      chk("busy", 8'h01, {7'h0, nv_busy});
      wait_idle();
      chk("pos", vals[i] & 8'h7f, {1'b0, wiper_pos[i]});
    end
    $display("test write done");
  endtask
  task automatic t_poll();
    run_cmd(1'b0, 1'b0, 8'h00, 8'h11);
    run_cmd(1'b0, 1'b0, 8'h00, 8'h22);
    chk("poll nack", 8'h01, {7'h0, rsp_nack});
    wait_idle();
    chk("pos0", 8'h11, {1'b0, wiper_pos[0]});
    $display("test poll done");
  endtask
  task automatic t_select();
    run_cmd(1'b0, 1'b1, 8'h01, 8'h44);
    chk("other nack", 8'h01, {7'h0, rsp_nack});
    chk("standby", 8'h01, {7'h0, standby});
    chk("pos1 kept", 8'h7f, {1'b0, wiper_pos[1]});
    sel_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    run_cmd(1'b0, 1'b1, 8'h01, 8'h44);
    chk("own nack", 8'h00, {7'h0, rsp_nack});
    wait_idle();
    chk("pos1", 8'h44, {1'b0, wiper_pos[1]});
    $display("test select done");
  endtask
  task automatic t_protect();
    wp <= 1'b1;
    run_cmd(1'b0, 1'b1, 8'h02, 8'h01);
    chk("locked nack", 8'h00, {7'h0, rsp_nack});
    wait_idle();
    chk("pos2 kept", 8'h35, {1'b0, wiper_pos[2]});
    $display("test protect done");
  endtask
  task automatic t_read();
    run_cmd(1'b1, 1'b1, 8'h01, 8'h00);
    chk("read data", 8'h44, rsp_data);
    chk("read nack", 8'h00, {7'h0, rsp_nack});
    wait_idle();
    $display("test read done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {mclk, cmd_valid, cmd_read, cmd_sel, sel_pin} = 5'h00;
    {srst, ce, wp} = 3'h7;
    cmd_addr = 8'h00;
    cmd_data = 8'h00;
    bad_count = 0;
    comparisons = 0;
    cyc = 0;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_write();
    t_poll();
    t_select();
    t_protect();
    t_read();
    end_sim();
  end
endmodule
